/* File: design/pcs_top.sv */
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - all bus latch values pass the modifier
// - even modifier parity raises modifier error
// - modifier error on clock C sets latch
// - modifier latch drives its panel lamp
// - modifier latch sets process check same pulse
// - six other checks also set process check
// - process check halts before next control-store cycle
// - check latches clear on reset or good C
// - even address register parity sets its latch
// - address latch drives lamp, sets process check
// - any even address bit count is error
// - process check suppresses clock A
// - only reset condition clears process check
module pcs_top #(
    parameter int CYCLE_CLKS = pcs_pkg::PROC_CYCLE_CLKS, // aclk edges per processor cycle
    parameter int EXT_N = pcs_pkg::EXT_CHECKS            // other check latch inputs
) (
    input wire logic aclk,                         // system clock, 125 MHz
    input wire logic aresetn,                      // synchronous reset, active low
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,           // write address
    input wire logic s_axi_awvalid,                // write address valid
    output logic s_axi_awready,                    // write address ready
    input wire logic [31:0] s_axi_wdata,           // write data
    input wire logic [3:0] s_axi_wstrb,            // write byte enables
    input wire logic s_axi_wvalid,                 // write data valid
    output logic s_axi_wready,                     // write data ready
    output logic [1:0] s_axi_bresp,                // write response
    output logic s_axi_bvalid,                     // write response valid
    input wire logic s_axi_bready,                 // write response ready
    input wire logic [3:0] s_axi_araddr,           // read address
    input wire logic s_axi_arvalid,                // read address valid
    output logic s_axi_arready,                    // read address ready
    output logic [31:0] s_axi_rdata,               // read data
    output logic [1:0] s_axi_rresp,                // read response
    output logic s_axi_rvalid,                     // read data valid
    input wire logic s_axi_rready,                 // read data ready
    // processor side
    input wire logic reset_key,                    // panel reset key, asynchronous
    input wire logic [pcs_pkg::MOD_W-1:0] bus_latch, // bus latch value into the modifier
    input wire logic [pcs_pkg::SAR_W-1:0] storage_address_reg, // address register with parity
    input wire logic [EXT_N-1:0] ext_check,        // other check latches, same clock
    output logic [pcs_pkg::MOD_W-1:0] mod_data,    // modifier output
    output logic clock_a,                          // gated clock A pulse
    output logic clock_c,                          // clock C pulse
    output logic cpu_halt,                         // processor stopped by a check
    output pcs_pkg::pcs_lamps_t lamps              // maintenance panel lamps
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    logic [7:0] phase;                             // divider count
    logic [7:0] next_phase;
    logic a_en;                                    // ungated clock A phase
    logic c_en;                                    // clock C phase
    logic key_s1;                                  // reset key sync stage one
    logic key_s2;                                  // reset key sync stage two
    logic swreset;                                 // software reset pulse, one cycle
    logic next_swreset;
    logic reset_cond;                              // combined reset condition
    logic override;                                // clock A override switch
    logic next_override;
    logic [pcs_pkg::MOD_W-1:0] next_mod_data;
    logic mod_latch;                               // modifier check latch
    logic mod_set;                                 // modifier latch set this clock C
    logic sar_latch;                               // address register check latch
    logic sar_set;                                 // address latch set this clock C
    logic proc_check;                              // process check latch
    logic next_proc_check;
    logic next_clock_a;
    logic next_clock_c;
    logic next_halt;
    pcs_pkg::pcs_lamps_t next_lamps;
    logic [31:0] status_word;                      // status as read by software
    // bus slave state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [3:0] waddr, next_waddr;                 // held write address
    logic [31:0] wdata, next_wdata;                // held write data
    logic [3:0] wstrb, next_wstrb;                 // held byte enables
    logic [1:0] bresp, next_bresp;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic do_write;                                // both halves held, commit now

    // ------------------------------------------------------------------------
    // phase divider: one processor cycle with clock A then clock C
    // ------------------------------------------------------------------------
    assign a_en = (phase == 8'(pcs_pkg::PHASE_A));
    assign c_en = (phase == 8'(CYCLE_CLKS / 2));

    always_comb begin
        next_phase = phase + 8'h01;
        if (phase == 8'(CYCLE_CLKS - 1)) begin
            next_phase = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 8'h00;
        end else begin
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------------------
    // reset key synchroniser; the key comes from the panel, not this clock
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_s1 <= 1'b0;
            key_s2 <= 1'b0;
        end else begin
            key_s1 <= reset_key;
            key_s2 <= key_s1;
        end
    end

    assign reset_cond = key_s2 | swreset;

    // ------------------------------------------------------------------------
    // modifier: every bus latch value is loaded at clock A time, so each
    // transfer is seen by the parity check at the following clock C
    // ------------------------------------------------------------------------
    always_comb begin
        next_mod_data = mod_data;
        if (a_en) begin
            next_mod_data = bus_latch;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mod_data <= '0;
        end else begin
            mod_data <= next_mod_data;
        end
    end

    // ------------------------------------------------------------------------
    // check latches
    // ------------------------------------------------------------------------
    pcs_check_latch #(
        .W(pcs_pkg::MOD_W)
    ) u_mod_check (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_c_en(c_en),
        .reset_cond(reset_cond),
        .data(mod_data),
        .latch(mod_latch),
        .set_now(mod_set)
    );

    pcs_check_latch #(
        .W(pcs_pkg::SAR_W)
    ) u_sar_check (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_c_en(c_en),
        .reset_cond(reset_cond),
        .data(storage_address_reg),
        .latch(sar_latch),
        .set_now(sar_set)
    );

    // ------------------------------------------------------------------------
    // process check latch; set on the very clock C that sets a check latch
    // ------------------------------------------------------------------------
    always_comb begin
        next_proc_check = proc_check;
        if (reset_cond) begin
            next_proc_check = 1'b0;
        end else if (mod_set | sar_set) begin
            next_proc_check = 1'b1;
        end else if (c_en & (|ext_check)) begin
            next_proc_check = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            proc_check <= 1'b0;
        end else begin
            proc_check <= next_proc_check;
        end
    end

    // ------------------------------------------------------------------------
    // registered outputs: clock pulses, halt and lamps
    // ------------------------------------------------------------------------
    always_comb begin
        // using the next value stops the very next clock A, not one later
        next_halt = next_proc_check & ~override;
        next_clock_a = a_en & ~next_halt;
        next_clock_c = c_en;
        next_lamps.mod_check = mod_set | (mod_latch & ~reset_cond & ~c_en);
        next_lamps.sar_check = sar_set | (sar_latch & ~reset_cond & ~c_en);
        next_lamps.proc_check = next_proc_check;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_a <= 1'b0;
            clock_c <= 1'b0;
            cpu_halt <= 1'b0;
            lamps <= '0;
        end else begin
            clock_a <= next_clock_a;
            clock_c <= next_clock_c;
            cpu_halt <= next_halt;
            lamps <= next_lamps;
        end
    end

    // ------------------------------------------------------------------------
    // status word as software sees it
    // ------------------------------------------------------------------------
    always_comb begin
        status_word = '0;
        status_word[pcs_pkg::STAT_MOD_BIT] = mod_latch;
        status_word[pcs_pkg::STAT_SAR_BIT] = sar_latch;
        status_word[pcs_pkg::STAT_PROC_BIT] = proc_check;
        status_word[pcs_pkg::STAT_EXT_LSB +: EXT_N] = ext_check;
    end

    // ------------------------------------------------------------------------
    // axi4-lite slave: address and data taken in either order, one at a time
    // ------------------------------------------------------------------------
    assign do_write = ~awready_q & ~wready_q & ~bvalid_q;

    always_comb begin
        next_awready = awready_q;
        next_wready = wready_q;
        next_bvalid = bvalid_q;
        next_waddr = waddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_bresp = bresp;
        next_override = override;
        next_swreset = 1'b0;
        if (awready_q & s_axi_awvalid) begin
            next_awready = 1'b0;
            next_waddr = s_axi_awaddr;
        end
        if (wready_q & s_axi_wvalid) begin
            next_wready = 1'b0;
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp = pcs_pkg::RESP_OKAY;
            if (waddr == pcs_pkg::CTRL_OFFSET) begin
                if (wstrb[0]) begin
                    // software steers the halt through the override switch
                    next_override = wdata[pcs_pkg::CTRL_OVERRIDE_BIT];
                    next_swreset = wdata[pcs_pkg::CTRL_SWRESET_BIT];
                end
            end else if (waddr != pcs_pkg::STATUS_OFFSET) begin
                next_bresp = pcs_pkg::RESP_SLVERR; // unmapped
            end
        end
        if (bvalid_q & s_axi_bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
    end

    always_comb begin
        next_arready = arready_q;
        next_rvalid = rvalid_q;
        next_rdata = rdata;
        next_rresp = rresp;
        if (arready_q & s_axi_arvalid) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = pcs_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (s_axi_araddr == pcs_pkg::CTRL_OFFSET) begin
                next_rdata[pcs_pkg::CTRL_OVERRIDE_BIT] = override;
            end else if (s_axi_araddr == pcs_pkg::STATUS_OFFSET) begin
                next_rdata = status_word;
            end else begin
                next_rresp = pcs_pkg::RESP_SLVERR; // unmapped reads zero
            end
        end
        if (rvalid_q & s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            waddr <= 4'h0;
            wdata <= 32'h0000_0000;
            wstrb <= 4'h0;
            bresp <= pcs_pkg::RESP_OKAY;
            rdata <= 32'h0000_0000;
            rresp <= pcs_pkg::RESP_OKAY;
            override <= pcs_pkg::CTRL_OVERRIDE_RST;
            swreset <= 1'b0;
        end else begin
            awready_q <= next_awready;
            wready_q <= next_wready;
            bvalid_q <= next_bvalid;
            arready_q <= next_arready;
            rvalid_q <= next_rvalid;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            bresp <= next_bresp;
            rdata <= next_rdata;
            rresp <= next_rresp;
            override <= next_override;
            swreset <= next_swreset;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

endmodule
`default_nettype wire

/* File: pkg/pcs_pkg.sv */
// ----------------------------------------------------------------------------
// constants and types shared by the parity check and stop block
// ----------------------------------------------------------------------------
package pcs_pkg;

    // clock and processor cycle timing
    localparam int CLK_PERIOD_NS = 8; // aclk period at 125 MHz
    localparam int PROC_CYCLE_NS = 64; // one processor cycle
    localparam int PROC_CYCLE_CLKS = PROC_CYCLE_NS / CLK_PERIOD_NS; // aclk edges per cycle
    localparam int PHASE_A = 0; // divider count that gives clock A

    // datapath widths
    localparam int MOD_W = 4; // modifier output width
    localparam int SAR_W = 15; // storage address register with parity
    localparam int EXT_CHECKS = 6; // other check latches feeding process check

    // register map, byte addresses
    localparam logic [3:0] CTRL_OFFSET = 4'h0; // control word
    localparam logic [3:0] STATUS_OFFSET = 4'h4; // check latch status

    // control field positions and reset value
    localparam int CTRL_OVERRIDE_BIT = 0; // keep clock A running despite a check
    localparam int CTRL_SWRESET_BIT = 1; // write one: raise the reset condition
    localparam logic CTRL_OVERRIDE_RST = 1'b0; // override off after reset

    // status field positions
    localparam int STAT_MOD_BIT = 0; // modifier check latch
    localparam int STAT_SAR_BIT = 1; // address register check latch
    localparam int STAT_PROC_BIT = 2; // process check latch
    localparam int STAT_EXT_LSB = 3; // first of the other check inputs

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0; // access done
    localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

    // panel lamp group
    typedef struct packed {
        logic proc_check; // process check lamp
        logic sar_check; // address register lamp
        logic mod_check; // modifier fault lamp
    } pcs_lamps_t;

endpackage

/* File: design/pcs_check_latch.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// one parity check latch: odd parity is good, even parity sets it on clock C
// ----------------------------------------------------------------------------
module pcs_check_latch #(
    parameter int W = 4 // width of the checked word
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic clk_c_en, // clock C phase pulse
    input wire logic reset_cond, // reset condition from the reset key or the software reset
    input wire logic [W-1:0] data, // word under check
    output logic latch, // check latch state
    output logic set_now // latch is being set on this clock C
);

    logic next_latch; // next latch state
    logic even_par; // even count of one bits

    // xnor reduction is high for zero, two, four ... ones
    assign even_par = ~^data;
    assign set_now = clk_c_en & ~reset_cond & even_par;

    // ------------------------------------------------------------------------
    // next latch value
    // ------------------------------------------------------------------------
    always_comb begin
        next_latch = latch;
        if (reset_cond) begin
            next_latch = 1'b0;
        end else if (clk_c_en) begin
            // the latch follows the check at each clock C, so a good word clears it
            next_latch = even_par;
        end
    end

    // ------------------------------------------------------------------------
    // latch register
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch <= 1'b0;
        end else begin
            latch <= next_latch;
        end
    end

endmodule
`default_nettype wire

/* File: dv/pcs_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker for the check and stop block
// ----------------------------------------
module pcs_top_asserts #(
    parameter int CYCLE_CLKS = 8, // aclk edges per cycle
    parameter int EXT_N = 6 // other checks
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset
    input wire logic reset_key, // panel key
    input wire logic [pcs_pkg::MOD_W-1:0] bus_latch, // modifier input
    input wire logic [pcs_pkg::SAR_W-1:0] storage_address_reg, // address
    input wire logic [EXT_N-1:0] ext_check, // other checks
    input wire logic [pcs_pkg::MOD_W-1:0] mod_data, // modifier output
    input wire logic clock_a, // gated clock a
    input wire logic clock_c, // clock c
    input wire logic cpu_halt, // stop
    input wire pcs_pkg::pcs_lamps_t lamps // lamps
);
    localparam int HALF = CYCLE_CLKS / 2; // a to c spacing
    logic [5:0] key_hist; // key samples: the sync delays clears
    logic quiet; // no key clear in flight
    // shift the key history
    always_ff @(posedge aclk) begin
        key_hist <= {key_hist[4:0], reset_key};
    end
    assign quiet = !reset_key && (key_hist == 6'h00);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // clock c pulse away from any key clear
    sequence seq_check_c;
        clock_c && quiet;
    endsequence
    // same, with some check lit
    sequence seq_any_check;
        seq_check_c ##0 (lamps.mod_check || lamps.sar_check || (|$past(ext_check, 1)));
    endsequence
    AST_MOD_PASS: assert property (clock_a |-> mod_data == $past(bus_latch, 1))
        else $error("modifier output differs from bus latch");
    AST_MOD_PARITY: assert property (seq_check_c |-> lamps.mod_check == ~^$past(mod_data, 1))
        else $error("modifier lamp differs from parity");
    AST_SAR_PARITY: assert property (seq_check_c |-> lamps.sar_check == ~^$past(storage_address_reg, 1))
        else $error("address lamp differs from parity");
    AST_PROC_SET: assert property (seq_any_check |-> lamps.proc_check)
        else $error("process check not set");
    AST_PROC_ON_C: assert property ($rose(lamps.proc_check) |-> clock_c)
        else $error("process check set off clock c");
    AST_PROC_STICKY: assert property (quiet && $past(lamps.proc_check) |-> lamps.proc_check)
        else $error("process check dropped without reset");
    AST_HALT_CAUSE: assert property (cpu_halt |-> lamps.proc_check)
        else $error("halt without process check");
    AST_NO_CLOCK_A: assert property (cpu_halt |-> !clock_a)
        else $error("clock a while halted");
    AST_A_TO_C: assert property (clock_a |-> ##HALF clock_c)
        else $error("clock c missing after clock a");
    AST_C_PERIOD: assert property (clock_c |-> ##CYCLE_CLKS clock_c)
        else $error("clock c not periodic");
endmodule
bind pcs_top pcs_top_asserts #(.CYCLE_CLKS(CYCLE_CLKS), .EXT_N(EXT_N)) i_pcs_top_asserts (
    .aclk, .aresetn, .reset_key, .bus_latch, .storage_address_reg, .ext_check,
    .mod_data, .clock_a, .clock_c, .cpu_halt, .lamps);
`default_nettype wire

/* File: dv/pcs_datapath_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// datapath and sequencer stand-in
// ----------------------------------------
module pcs_datapath_model #(
    parameter int EXT_N = 6 // other checks
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset
    input wire logic clock_a, // steps the datapath
    input wire logic mod_bad, // even parity on bus latch
    input wire logic sar_bad, // even parity in address
    input wire logic [EXT_N-1:0] ext_err, // other checks
    input wire logic key_press, // hold reset key
    output logic [pcs_pkg::MOD_W-1:0] bus_latch, // modifier input
    output logic [pcs_pkg::SAR_W-1:0] storage_address_reg, // address
    output logic [EXT_N-1:0] ext_check, // other checks
    output logic reset_key // panel key
);
    logic [pcs_pkg::MOD_W-2:0] cnt; // data pattern
    logic [pcs_pkg::SAR_W-2:0] addr; // address pattern
    // advance only on clock a, so a halt freezes the datapath
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
            addr <= '0;
        end else if (clock_a) begin
            cnt <= cnt + 1'b1;
            addr <= addr + 14'h0123;
        end
    end
    // parity bit makes the word odd unless a fault is asked for
    assign bus_latch = {~^cnt ^ mod_bad, cnt};
    assign storage_address_reg = {~^addr ^ sar_bad, addr};
    assign ext_check = ext_err;
    assign reset_key = key_press;
endmodule
`default_nettype wire

/* File: dv/pcs_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
        end \
    end
module pcs_top_tb_top;
    localparam int CYC = 4; // short cycle keeps the run brief
    localparam int EXT = pcs_pkg::EXT_CHECKS; // other checks
    logic aclk = 1'b0, aresetn = 1'b0; // clock, reset
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hf, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic reset_key, clock_a, clock_c, cpu_halt; // processor side
    logic [3:0] bus_latch, mod_data;
    logic [14:0] storage_address_reg;
    logic [EXT-1:0] ext_check, ext_err = '0;
    logic mod_bad = 1'b0, sar_bad = 1'b0, key_press = 1'b0; // fault controls
    pcs_pkg::pcs_lamps_t lamps;
    logic [3:0] obs; // flags polled by wait_until
    int fail_count = 0, check_count = 0;
    assign obs = {lamps.sar_check, lamps.mod_check, lamps.proc_check, cpu_halt};
    always #4 aclk = ~aclk;
    pcs_top #(.CYCLE_CLKS(CYC), .EXT_N(EXT)) i_pcs_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .reset_key, .bus_latch, .storage_address_reg, .ext_check, .mod_data, .clock_a, .clock_c,
        .cpu_halt, .lamps);
    pcs_datapath_model #(.EXT_N(EXT)) i_pcs_datapath_model (
        .aclk, .aresetn, .clock_a, .mod_bad, .sar_bad, .ext_err, .key_press,
        .bus_latch, .storage_address_reg, .ext_check, .reset_key);
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask
    // bounded poll of one panel flag
    task automatic wait_until(input int idx, input logic v);
        int n;
        n = 0;
        while (obs[idx] !== v && n < 64) begin
            @(posedge aclk);
            n++;
        end
        `CHK("panel flag", v, obs[idx])
    endtask
    task automatic count_a(input int cycles, input int exp);
        int n;
        n = 0;
        repeat (cycles) begin
            @(posedge aclk);
            if (clock_a === 1'b1) n++;
        end
        `CHK("clock a pulses", exp, n)
    endtask
    task automatic press_key();
        key_press <= 1'b1;
        repeat (2) @(posedge aclk);
        key_press <= 1'b0;
        wait_until(1, 1'b0);
    endtask
    task automatic t_regs();
        axr(pcs_pkg::CTRL_OFFSET, 32'h0000_0000, pcs_pkg::RESP_OKAY);
        axr(pcs_pkg::STATUS_OFFSET, 32'h0000_0000, pcs_pkg::RESP_OKAY);
        axw(4'h8, 32'h0000_0001, pcs_pkg::RESP_SLVERR);
        axr(4'h8, 32'h0000_0000, pcs_pkg::RESP_SLVERR);
        axr(4'h2, 32'h0000_0000, pcs_pkg::RESP_SLVERR);
        axw(pcs_pkg::STATUS_OFFSET, 32'hffff_ffff, pcs_pkg::RESP_OKAY);
        axr(pcs_pkg::STATUS_OFFSET, 32'h0000_0000, pcs_pkg::RESP_OKAY);
    endtask
    // modifier fault with the override on, so clock a keeps running
    task automatic t_mod();
        axw(pcs_pkg::CTRL_OFFSET, 32'h0000_0001, pcs_pkg::RESP_OKAY);
        axr(pcs_pkg::CTRL_OFFSET, 32'h0000_0001, pcs_pkg::RESP_OKAY);
        mod_bad <= 1'b1;
        wait_until(1, 1'b1);
        `CHK("mod lamp", 1'b1, lamps.mod_check)
        `CHK("halt", 1'b0, cpu_halt)
        axr(pcs_pkg::STATUS_OFFSET, 32'h0000_0005, pcs_pkg::RESP_OKAY);
        mod_bad <= 1'b0;
        wait_until(2, 1'b0);
        `CHK("proc lamp", 1'b1, lamps.proc_check)
        press_key();
        axw(pcs_pkg::CTRL_OFFSET, 32'h0000_0000, pcs_pkg::RESP_OKAY);
    endtask
    task automatic t_sar();
        sar_bad <= 1'b1;
        wait_until(0, 1'b1);
        `CHK("sar lamp", 1'b1, lamps.sar_check)
        count_a(3 * CYC, 0);
        sar_bad <= 1'b0;
        wait_until(3, 1'b0);
        `CHK("halt", 1'b1, cpu_halt)
        press_key();
        count_a(2 * CYC, 2);
    endtask
    task automatic t_ext();
        for (int i = 0; i < EXT; i++) begin
            ext_err <= EXT'(1) << i;
            wait_until(0, 1'b1);
            axr(pcs_pkg::STATUS_OFFSET, 32'h0000_0004 | (32'h0000_0008 << i), pcs_pkg::RESP_OKAY);
            ext_err <= '0;
            press_key();
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_mod();
        t_sar();
        t_ext();
        end_of_test();
    end
    // watchdog: far beyond the test length
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
